//--- design/rmc_pkg.sv
package rmc_pkg;

  // register word indices; byte address is four times the index
  localparam logic [9:0] RMC_IDX_SETUP_B = 10'h10D;
  localparam logic [9:0] RMC_IDX_SETUP_C = 10'h10E;
  localparam logic [9:0] RMC_IDX_SETUP_D = 10'h10F;
  localparam logic [9:0] RMC_IDX_SETUP_E = 10'h110;
  localparam logic [9:0] RMC_IDX_SETUP_F = 10'h111;
  localparam logic [9:0] RMC_IDX_SETUP_G = 10'h112;
  localparam logic [9:0] RMC_IDX_SETUP_H = 10'h113;
  localparam logic [9:0] RMC_IDX_STATUS  = 10'h120;

  // slots in the byte array, counted from radio_setup_b
  localparam int unsigned RMC_NUM_SETUP = 7;
  localparam logic [2:0]  RMC_SLOT_B    = 3'h0;
  localparam logic [2:0]  RMC_SLOT_C    = 3'h1;
  localparam logic [2:0]  RMC_SLOT_D    = 3'h2;
  localparam logic [2:0]  RMC_SLOT_E    = 3'h3;
  localparam logic [2:0]  RMC_SLOT_G    = 3'h5;
  localparam logic [2:0]  RMC_SLOT_H    = 3'h6;

  // field positions
  localparam int RMC_RATE_HI_MSB = 3;
  localparam int RMC_RATE_HI_LSB = 0;
  localparam int RMC_TONE_HI_MSB = 7;
  localparam int RMC_TONE_HI_LSB = 4;
  localparam int RMC_TUNE_MSB    = 7;
  localparam int RMC_TUNE_LSB    = 2;
  localparam int RMC_PHASE_MSB   = 1;
  localparam int RMC_PHASE_LSB   = 0;
  localparam int RMC_GAIN_MSB    = 7;
  localparam int RMC_GAIN_LSB    = 6;
  localparam int RMC_LUT_MSB     = 5;
  localparam int RMC_LUT_LSB     = 4;

  localparam logic [7:0]  RMC_SETUP_RST   = 8'h00;
  localparam logic [7:0]  RMC_FILT_MIN    = 8'h01;
  localparam logic [1:0]  RMC_TOL_NONE    = 2'h0;
  localparam int unsigned RMC_CODE_W      = 12;
  localparam int unsigned RMC_HZ_W        = 19;
  localparam int unsigned RMC_KHZ_W       = 9;
  localparam int unsigned RMC_RATE_STEP   = 100;
  localparam int unsigned RMC_TONE_STEP   = 100;
  localparam int unsigned RMC_FILT_STEP   = 2;

  localparam logic [1:0] RMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RMC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RMC_LUT_ROM  = 2'h0,
    RMC_LUT_RX   = 2'h1,
    RMC_LUT_TX   = 2'h2,
    RMC_LUT_BOTH = 2'h3
  } rmc_lut_e;

  typedef enum logic [1:0] {
    RMC_GAIN_FREE   = 2'h0,
    RMC_GAIN_MANUAL = 2'h1,
    RMC_GAIN_HOLD   = 2'h2,
    RMC_GAIN_LOCK   = 2'h3
  } rmc_gain_e;

  typedef enum logic [2:0] {
    RMC_GS_IDLE  = 3'h1,
    RMC_GS_TRACK = 3'h2,
    RMC_GS_LOCK  = 3'h4
  } rmc_gstate_e;

endpackage

//--- design/rmc_gain_ctl.sv
`timescale 1ns/1ns
`default_nettype none

module rmc_gain_ctl
  import rmc_pkg::*;
(
  input  wire logic      i_core_clk,
  input  wire logic      i_rst,
  input  wire rmc_gain_e i_policy,
  input  wire logic      i_rx_active,
  input  wire logic      i_preamble_det,
  input  wire logic      i_sync_match,
  input  wire logic [1:0] i_preamble_tol,
  output logic           o_track,
  output logic           o_hold,
  output logic           o_manual
);

  rmc_gstate_e state_r;
  rmc_gstate_e state_nxt;
  logic        track_nxt;
  logic        hold_nxt;
  logic        manual_nxt;
  logic        lock_evt;

  always_comb
  begin
    // sync word locks only without preamble tolerance
    lock_evt = (i_preamble_tol == RMC_TOL_NONE) ? i_sync_match : i_preamble_det;
    state_nxt = state_r;
    case (state_r)
      RMC_GS_IDLE:
        if (i_rx_active)
          state_nxt = RMC_GS_TRACK;
      RMC_GS_TRACK:
        if (!i_rx_active)
          state_nxt = RMC_GS_IDLE;
        else if (i_policy == RMC_GAIN_LOCK && lock_evt)
          state_nxt = RMC_GS_LOCK;
      RMC_GS_LOCK:
        if (!i_rx_active)
          state_nxt = RMC_GS_IDLE;
      default:
        state_nxt = RMC_GS_IDLE;
    endcase
    // policy decode of the gain loop
    track_nxt  = (state_nxt == RMC_GS_TRACK) &&
                 (i_policy == RMC_GAIN_FREE || i_policy == RMC_GAIN_LOCK);
    hold_nxt   = (state_nxt == RMC_GS_LOCK) ||
                 (i_rx_active && i_policy == RMC_GAIN_HOLD);
    manual_nxt = (i_policy == RMC_GAIN_MANUAL);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r  <= RMC_GS_IDLE;
      o_track  <= 1'b0;
      o_hold   <= 1'b0;
      o_manual <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      o_track  <= track_nxt;
      o_hold   <= hold_nxt;
      o_manual <= manual_nxt;
    end
  end

endmodule

`default_nettype wire

//--- design/rmc_radio_setup.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - The top four bits of the 12-bit rate code sit in the low nibble of radio_setup_b.
// - The symbol rate in bits per second is the 12-bit rate code times one hundred.
// - The top four bits of the 12-bit tone offset sit in the high nibble of radio_setup_b.
// - radio_setup_c gives the low tone offset byte, and the tone offset in hertz is the code times one hundred.
// - All of radio_setup_d is the correlator bandwidth.
// - The detector filter width in kilohertz is twice radio_setup_e, which software keeps in 1 to 255.
// - With table select 1 or 3 the receive loop tuning field steers the receive loop bandwidth.
// - The two low bits of radio_setup_g are the correlator phase.
// - The gain policy field picks free running, manual, hold, or lock after preamble or sync word.
// - Under the lock policy, a sync word match locks gain only when preamble tolerance is zero.
// - By default loop bandwidth comes from the built-in tables, narrower in receive.
// - Table select picks built-in for both, custom receive, custom transmit, or custom for both.
module rmc_radio_setup
  import rmc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic [ADDR_W-1:0]    i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  input  wire logic [ADDR_W-1:0]    i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  input  wire logic [7:0]           i_rate_low,
  input  wire logic                 i_enter_tx,
  input  wire logic                 i_enter_rx,
  input  wire logic                 i_rx_active,
  input  wire logic                 i_preamble_det,
  input  wire logic                 i_sync_match,
  input  wire logic [1:0]           i_preamble_tol,
  output logic [RMC_CODE_W-1:0]     o_rate_code,
  output logic [RMC_HZ_W-1:0]       o_symbol_rate_bps,
  output logic [RMC_CODE_W-1:0]     o_tone_code,
  output logic [RMC_HZ_W-1:0]       o_tone_offset_hz,
  output logic [7:0]                o_corr_bw,
  output logic [1:0]                o_corr_phase,
  output logic [RMC_KHZ_W-1:0]      o_filt_width_khz,
  output logic [5:0]                o_rx_loop_tune,
  output logic                      o_rx_lut_custom,
  output logic                      o_tx_lut_custom,
  output logic                      o_loop_bw_narrow,
  output logic                      o_gain_track,
  output logic                      o_gain_hold,
  output logic                      o_gain_manual
);

  // write channel state
  logic              aw_full_r;
  logic              aw_full_nxt;
  logic              w_full_r;
  logic              w_full_nxt;
  logic [9:0]        wr_idx_r;
  logic [9:0]        wr_idx_nxt;
  logic [7:0]        wr_byte_r;
  logic [7:0]        wr_byte_nxt;
  logic              wr_lane_r;
  logic              wr_lane_nxt;
  logic              awready_nxt;
  logic              wready_nxt;
  logic              bvalid_nxt;
  logic [1:0]        bresp_nxt;
  logic              wr_fire;
  logic              wr_hit;
  logic [2:0]        wr_slot;

  // read channel state
  logic              arready_nxt;
  logic              rvalid_nxt;
  logic [31:0]       rdata_nxt;
  logic [1:0]        rresp_nxt;
  logic [9:0]        rd_idx;
  logic [8:0]        rd_word;

  // staged bytes as software wrote them
  logic [7:0]        setup_r   [RMC_NUM_SETUP];
  logic [7:0]        setup_nxt [RMC_NUM_SETUP];

  // applied settings
  logic              enter_any;
  logic              applied_r;
  logic              applied_nxt;
  rmc_lut_e          lut_r;
  rmc_lut_e          lut_nxt;
  rmc_gain_e         gain_r;
  rmc_gain_e         gain_nxt;
  logic [5:0]        tune_r;
  logic [5:0]        tune_nxt;
  logic [RMC_CODE_W-1:0] rate_nxt;
  logic [RMC_HZ_W-1:0]   rate_bps_nxt;
  logic [RMC_CODE_W-1:0] tone_nxt;
  logic [RMC_HZ_W-1:0]   tone_hz_nxt;
  logic [7:0]        corr_bw_nxt;
  logic [1:0]        corr_phase_nxt;
  logic [7:0]        filt_code;
  logic [RMC_KHZ_W-1:0]  filt_khz_nxt;
  logic [5:0]        rx_tune_nxt;
  logic              rx_custom_nxt;
  logic              tx_custom_nxt;
  logic              narrow_nxt;
  logic              filt_zero;

  // map lookup: bit 8 is hit, bits 7:0 the byte
  function automatic logic [8:0] map_read(input logic [9:0] idx);
    logic [8:0] res;
    res = 9'h000;
    if (idx >= RMC_IDX_SETUP_B && idx <= RMC_IDX_SETUP_H)
      res = {1'b1, setup_r[3'(idx - RMC_IDX_SETUP_B)]};
    else if (idx == RMC_IDX_STATUS)
      res = {1'b1, gain_r, lut_r, 1'b0, filt_zero, o_gain_hold, applied_r};
    return res;
  endfunction

  assign wr_fire  = aw_full_r && w_full_r && !o_bvalid;
  assign wr_hit   = (wr_idx_r >= RMC_IDX_SETUP_B) && (wr_idx_r <= RMC_IDX_SETUP_H);
  assign wr_slot  = 3'(wr_idx_r - RMC_IDX_SETUP_B);
  assign rd_idx   = i_araddr[11:2];
  assign enter_any = i_enter_tx || i_enter_rx;
  assign filt_zero = (setup_r[RMC_SLOT_E] == RMC_SETUP_RST);

  // write address and data are taken in either order, answered once both are held
  always_comb
  begin
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    wr_idx_nxt  = wr_idx_r;
    wr_byte_nxt = wr_byte_r;
    wr_lane_nxt = wr_lane_r;
    bvalid_nxt  = o_bvalid;
    bresp_nxt   = o_bresp;
    if (i_awvalid && o_awready)
    begin
      aw_full_nxt = 1'b1;
      wr_idx_nxt  = i_awaddr[11:2];
    end
    if (i_wvalid && o_wready)
    begin
      w_full_nxt  = 1'b1;
      wr_byte_nxt = i_wdata[7:0];
      wr_lane_nxt = i_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_hit || wr_idx_r == RMC_IDX_STATUS) ? RMC_RESP_OKAY : RMC_RESP_SLVERR;
    end
    if (o_bvalid && i_bready)
      bvalid_nxt = 1'b0;
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt  = !w_full_nxt && !bvalid_nxt;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      wr_idx_r  <= 10'h000;
      wr_byte_r <= RMC_SETUP_RST;
      wr_lane_r <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RMC_RESP_OKAY;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      wr_idx_r  <= wr_idx_nxt;
      wr_byte_r <= wr_byte_nxt;
      wr_lane_r <= wr_lane_nxt;
      o_awready <= awready_nxt;
      o_wready  <= wready_nxt;
      o_bvalid  <= bvalid_nxt;
      o_bresp   <= bresp_nxt;
    end
  end

  // read: one cycle from address taken to data valid
  always_comb
  begin
    // looked up here so that a byte written under a steady read address is seen again
    rd_word     = map_read(rd_idx);
    arready_nxt = o_arready;
    rvalid_nxt  = o_rvalid;
    rdata_nxt   = o_rdata;
    rresp_nxt   = o_rresp;
    if (i_arvalid && o_arready)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = {24'h000000, rd_word[7:0]};
      rresp_nxt   = rd_word[8] ? RMC_RESP_OKAY : RMC_RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      arready_nxt = 1'b1;
      rvalid_nxt  = 1'b0;
    end
    else if (!o_rvalid)
      arready_nxt = 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= RMC_RESP_OKAY;
    end
    else
    begin
      o_arready <= arready_nxt;
      o_rvalid  <= rvalid_nxt;
      o_rdata   <= rdata_nxt;
      o_rresp   <= rresp_nxt;
    end
  end

  // staged bytes; the reserved byte is stored as written
  always_comb
  begin
    for (int i = 0; i < RMC_NUM_SETUP; i++)
      setup_nxt[i] = setup_r[i];
    if (wr_fire && wr_hit && wr_lane_r)
      setup_nxt[wr_slot] = wr_byte_r;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < RMC_NUM_SETUP; i++)
        setup_r[i] <= RMC_SETUP_RST;
    end
    else
    begin
      for (int i = 0; i < RMC_NUM_SETUP; i++)
        setup_r[i] <= setup_nxt[i];
    end
  end

  // settings move to the radio only on entry to transmit or receive
  always_comb
  begin
    applied_nxt    = applied_r;
    lut_nxt        = lut_r;
    gain_nxt       = gain_r;
    tune_nxt       = tune_r;
    rate_nxt       = o_rate_code;
    rate_bps_nxt   = o_symbol_rate_bps;
    tone_nxt       = o_tone_code;
    tone_hz_nxt    = o_tone_offset_hz;
    corr_bw_nxt    = o_corr_bw;
    corr_phase_nxt = o_corr_phase;
    filt_khz_nxt   = o_filt_width_khz;
    filt_code      = setup_r[RMC_SLOT_E];
    if (filt_code == RMC_SETUP_RST)
      filt_code = RMC_FILT_MIN;
    if (enter_any)
    begin
      applied_nxt = 1'b1;
      rate_nxt = {setup_r[RMC_SLOT_B][RMC_RATE_HI_MSB:RMC_RATE_HI_LSB], i_rate_low};
      rate_bps_nxt = RMC_HZ_W'(rate_nxt * RMC_RATE_STEP);
      tone_nxt = {setup_r[RMC_SLOT_B][RMC_TONE_HI_MSB:RMC_TONE_HI_LSB],
                  setup_r[RMC_SLOT_C]};
      tone_hz_nxt = RMC_HZ_W'(tone_nxt * RMC_TONE_STEP);
      corr_bw_nxt = setup_r[RMC_SLOT_D];
      corr_phase_nxt = setup_r[RMC_SLOT_G][RMC_PHASE_MSB:RMC_PHASE_LSB];
      filt_khz_nxt = RMC_KHZ_W'(filt_code * RMC_FILT_STEP);
      tune_nxt = setup_r[RMC_SLOT_G][RMC_TUNE_MSB:RMC_TUNE_LSB];
      lut_nxt  = rmc_lut_e'(setup_r[RMC_SLOT_H][RMC_LUT_MSB:RMC_LUT_LSB]);
      gain_nxt = rmc_gain_e'(setup_r[RMC_SLOT_H][RMC_GAIN_MSB:RMC_GAIN_LSB]);
    end
  end

  // table selection and loop bandwidth steering
  always_comb
  begin
    rx_custom_nxt = (lut_r == RMC_LUT_RX) || (lut_r == RMC_LUT_BOTH);
    tx_custom_nxt = (lut_r == RMC_LUT_TX) || (lut_r == RMC_LUT_BOTH);
    // tuning field ignored under built-in receive tables, whatever was written
    rx_tune_nxt = rx_custom_nxt ? tune_r : 6'h00;
    // built-in tables pick the narrow loop while receiving
    narrow_nxt = i_rx_active && !rx_custom_nxt;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      applied_r         <= 1'b0;
      lut_r             <= RMC_LUT_ROM;
      gain_r            <= RMC_GAIN_FREE;
      tune_r            <= 6'h00;
      o_rate_code       <= '0;
      o_symbol_rate_bps <= '0;
      o_tone_code       <= '0;
      o_tone_offset_hz  <= '0;
      o_corr_bw         <= RMC_SETUP_RST;
      o_corr_phase      <= 2'h0;
      o_filt_width_khz  <= '0;
      o_rx_loop_tune    <= 6'h00;
      o_rx_lut_custom   <= 1'b0;
      o_tx_lut_custom   <= 1'b0;
      o_loop_bw_narrow  <= 1'b0;
    end
    else
    begin
      applied_r         <= applied_nxt;
      lut_r             <= lut_nxt;
      gain_r            <= gain_nxt;
      tune_r            <= tune_nxt;
      o_rate_code       <= rate_nxt;
      o_symbol_rate_bps <= rate_bps_nxt;
      o_tone_code       <= tone_nxt;
      o_tone_offset_hz  <= tone_hz_nxt;
      o_corr_bw         <= corr_bw_nxt;
      o_corr_phase      <= corr_phase_nxt;
      o_filt_width_khz  <= filt_khz_nxt;
      o_rx_loop_tune    <= rx_tune_nxt;
      o_rx_lut_custom   <= rx_custom_nxt;
      o_tx_lut_custom   <= tx_custom_nxt;
      o_loop_bw_narrow  <= narrow_nxt;
    end
  end

  // gain loop follows the applied policy
  rmc_gain_ctl u_gain
  (
    .i_core_clk     (i_core_clk),
    .i_rst          (i_rst),
    .i_policy       (gain_r),
    .i_rx_active    (i_rx_active),
    .i_preamble_det (i_preamble_det),
    .i_sync_match   (i_sync_match),
    .i_preamble_tol (i_preamble_tol),
    .o_track        (o_gain_track),
    .o_hold         (o_gain_hold),
    .o_manual       (o_gain_manual)
  );

endmodule

`default_nettype wire

//--- verification/rmc_radio_setup_props.sv
`timescale 1ns/1ns
`default_nettype none
module rmc_radio_setup_props
  import rmc_pkg::*;
(
  input wire logic                 i_core_clk,
  input wire logic                 i_rst,
  input wire logic                 i_enter_tx,
  input wire logic                 i_enter_rx,
  input wire logic                 i_rx_active,
  input wire logic                 i_sync_match,
  input wire logic [1:0]           i_preamble_tol,
  input wire logic [RMC_CODE_W-1:0] o_rate_code,
  input wire logic [RMC_HZ_W-1:0]  o_symbol_rate_bps,
  input wire logic [RMC_CODE_W-1:0] o_tone_code,
  input wire logic [RMC_HZ_W-1:0]  o_tone_offset_hz,
  input wire logic [7:0]           o_corr_bw,
  input wire logic [1:0]           o_corr_phase,
  input wire logic [RMC_KHZ_W-1:0] o_filt_width_khz,
  input wire logic [5:0]           o_rx_loop_tune,
  input wire logic                 o_rx_lut_custom,
  input wire logic                 o_tx_lut_custom,
  input wire logic                 o_loop_bw_narrow,
  input wire logic                 o_gain_track,
  input wire logic                 o_gain_hold,
  input wire logic                 o_gain_manual
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_rate_scale: assert property (o_symbol_rate_bps == RMC_HZ_W'(o_rate_code * 100))
    else $error("symbol rate differs from rate code times 100");
  a_tone_scale: assert property (o_tone_offset_hz == RMC_HZ_W'(o_tone_code * 100))
    else $error("tone offset differs from tone code times 100");
  a_filt_even: assert property ($changed(o_filt_width_khz) |-> o_filt_width_khz >= 2 && !o_filt_width_khz[0])
    else $error("filter width not twice a byte of 1 to 255");
  a_apply_only: assert property (!i_enter_tx && !i_enter_rx |=> $stable(o_rate_code) && $stable(o_tone_code)
    && $stable(o_corr_bw) && $stable(o_corr_phase) && $stable(o_filt_width_khz))
    else $error("applied setting moved without an entry pulse");
  a_lut_apply: assert property (!i_enter_tx && !i_enter_rx && !$past(i_enter_tx) && !$past(i_enter_rx)
    |=> $stable(o_rx_lut_custom) && $stable(o_tx_lut_custom) && $stable(o_rx_loop_tune))
    else $error("table select outputs moved without an entry pulse");
  a_tune_custom: assert property (o_rx_loop_tune != 6'h00 |-> o_rx_lut_custom)
    else $error("loop tuning applied without custom receive table");
  a_narrow_rx: assert property (o_loop_bw_narrow |-> $past(i_rx_active))
    else $error("narrow loop flag without receive");
  a_gain_excl: assert property (!(o_gain_track && (o_gain_hold || o_gain_manual)))
    else $error("gain tracking together with hold or manual");
  a_track_rx: assert property ($rose(o_gain_track) |-> $past(i_rx_active) || $past(i_rx_active, 2))
    else $error("gain tracking began without receive");
  a_sync_lock: assert property ($rose(o_gain_hold) && $past(o_gain_track) && $past(i_preamble_tol) == RMC_TOL_NONE
    |-> $past(i_sync_match) || $past(i_sync_match, 2))
    else $error("gain locked without sync match at zero tolerance");
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

bind rmc_radio_setup rmc_radio_setup_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_enter_tx(i_enter_tx), .i_enter_rx(i_enter_rx), .i_rx_active(i_rx_active), .i_sync_match(i_sync_match),
  .i_preamble_tol(i_preamble_tol), .o_rate_code(o_rate_code), .o_symbol_rate_bps(o_symbol_rate_bps),
  .o_tone_code(o_tone_code), .o_tone_offset_hz(o_tone_offset_hz), .o_corr_bw(o_corr_bw),
  .o_corr_phase(o_corr_phase), .o_filt_width_khz(o_filt_width_khz), .o_rx_loop_tune(o_rx_loop_tune),
  .o_rx_lut_custom(o_rx_lut_custom), .o_tx_lut_custom(o_tx_lut_custom), .o_loop_bw_narrow(o_loop_bw_narrow),
  .o_gain_track(o_gain_track), .o_gain_hold(o_gain_hold), .o_gain_manual(o_gain_manual));

module tb;
  import rmc_pkg::*;
  logic                  i_core_clk = 1'b0;
  logic                  i_rst = 1'b1;
  logic [11:0]           i_awaddr = '0, i_araddr = '0;
  logic [31:0]           i_wdata = '0;
  logic [3:0]            i_wstrb = '0;
  logic                  i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [7:0]            i_rate_low = '0;
  logic                  i_enter_tx = 0, i_enter_rx = 0, i_rx_active = 0, i_preamble_det = 0, i_sync_match = 0;
  logic [1:0]            i_preamble_tol = '0;
  logic                  o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]            o_bresp, o_rresp, o_corr_phase;
  logic [31:0]           o_rdata;
  logic [RMC_CODE_W-1:0] o_rate_code, o_tone_code;
  logic [RMC_HZ_W-1:0]   o_symbol_rate_bps, o_tone_offset_hz;
  logic [7:0]            o_corr_bw;
  logic [RMC_KHZ_W-1:0]  o_filt_width_khz;
  logic [5:0]            o_rx_loop_tune;
  logic                  o_rx_lut_custom, o_tx_lut_custom, o_loop_bw_narrow, o_gain_track, o_gain_hold, o_gain_manual;
  int                    error_cnt = 0, n_compared = 0;
  logic [1:0]            wq[$];
  logic [33:0]           rq[$];
  logic [1:0]            ew;
  logic [33:0]           er;
  logic [7:0]            rb[7];

  always #2 i_core_clk = ~i_core_clk;

  rmc_radio_setup #(.ADDR_W(12)) DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .i_rate_low(i_rate_low), .i_enter_tx(i_enter_tx), .i_enter_rx(i_enter_rx),
    .i_rx_active(i_rx_active), .i_preamble_det(i_preamble_det), .i_sync_match(i_sync_match),
    .i_preamble_tol(i_preamble_tol), .o_rate_code(o_rate_code), .o_symbol_rate_bps(o_symbol_rate_bps),
    .o_tone_code(o_tone_code), .o_tone_offset_hz(o_tone_offset_hz), .o_corr_bw(o_corr_bw),
    .o_corr_phase(o_corr_phase), .o_filt_width_khz(o_filt_width_khz), .o_rx_loop_tune(o_rx_loop_tune),
    .o_rx_lut_custom(o_rx_lut_custom), .o_tx_lut_custom(o_tx_lut_custom), .o_loop_bw_narrow(o_loop_bw_narrow),
    .o_gain_track(o_gain_track), .o_gain_hold(o_gain_hold), .o_gain_manual(o_gain_manual));

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] rsp);
    wq.push_back(rsp);
    @(posedge i_core_clk);
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {24'h0, d};
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      if ((i_awvalid && o_awready) === 1'b1)
        i_awvalid <= 1'b0;
      if ((i_wvalid && o_wready) === 1'b1)
        i_wvalid <= 1'b0;
    end while ((o_bvalid && i_bready) !== 1'b1);
    i_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [9:0] idx, input logic [33:0] exp);
    rq.push_back(exp);
    @(posedge i_core_clk);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      if ((i_arvalid && o_arready) === 1'b1)
        i_arvalid <= 1'b0;
    end while ((o_rvalid && i_rready) !== 1'b1);
    i_rready <= 1'b0;
  endtask

  // one-cycle pulse: 0 enter tx, 1 enter rx, 2 preamble found, 3 sync match; waits for outputs to settle
  task automatic pulse(input int w);
    @(posedge i_core_clk);
    {i_sync_match, i_preamble_det, i_enter_rx, i_enter_tx} <= 4'(1 << w);
    @(posedge i_core_clk);
    {i_sync_match, i_preamble_det, i_enter_rx, i_enter_tx} <= 4'h0;
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask

  always @(posedge i_core_clk)
  begin
    if ((o_bvalid && i_bready) === 1'b1)
    begin
      ew = wq.pop_front();
      `CHK(o_bresp, ew)
    end
    if ((o_rvalid && i_rready) === 1'b1)
    begin
      er = rq.pop_front();
      `CHK({o_rresp, o_rdata}, er)
    end
  end

  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial
  begin : main
    logic [1:0]  lut;
    logic [7:0]  rl;
    logic [7:0]  pd;
    logic [11:0] code;
    logic [11:0] tone;
    void'($urandom(50));
    pd = 8'h00;
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // table select and gain policy walk all four codes together
    for (int i = 0; i < 4; i++)
    begin
      lut = 2'(i);
      rb[0] = 8'($urandom);
      rb[1] = 8'($urandom);
      rb[2] = 8'($urandom);
      rl = 8'($urandom);
      // random case keeps the detector filter near three quarters of the symbol rate
      rb[3] = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'(({rb[0][3:0], rl} * 3) / 80 + 1);
      rb[4] = 8'h00;
      rb[5] = {lut[0] ? 6'($urandom) : 6'h00, 2'($urandom)};
      rb[6] = {lut, lut, 4'h0};
      for (int k = 0; k < 7; k++)
        axi_wr(RMC_IDX_SETUP_B + 10'(k), rb[k], 4'h1, RMC_RESP_OKAY);
      for (int k = 0; k < 7; k++)
        axi_rd(RMC_IDX_SETUP_B + 10'(k), {RMC_RESP_OKAY, 24'h0, rb[k]});
      i_rate_low <= rl;
      `CHK(o_corr_bw, pd)
      pulse(i % 2);
      code = {rb[0][3:0], rl};
      tone = {rb[0][7:4], rb[1]};
      `CHK(o_rate_code, code)
      `CHK(o_symbol_rate_bps, RMC_HZ_W'(code * 100))
      `CHK(o_tone_code, tone)
      `CHK(o_tone_offset_hz, RMC_HZ_W'(tone * 100))
      `CHK(o_corr_bw, rb[2])
      `CHK(o_filt_width_khz, RMC_KHZ_W'((rb[3] == 8'h00 ? 1 : rb[3]) * 2))
      `CHK(o_corr_phase, rb[5][1:0])
      `CHK(o_rx_loop_tune, lut[0] ? rb[5][7:2] : 6'h00)
      `CHK({o_tx_lut_custom, o_rx_lut_custom}, lut)
      pd = rb[2];
      @(posedge i_core_clk);
      i_rx_active <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      #1;
      `CHK(o_loop_bw_narrow, !lut[0])
      `CHK({o_gain_manual, o_gain_hold, o_gain_track}, 3'(lut == 1 ? 4 : lut == 2 ? 2 : 1))
      if (lut == 2'h3)
      begin
        pulse(2);
        `CHK(o_gain_hold, 1'b0)
        pulse(3);
        `CHK(o_gain_hold, 1'b1)
        // with a preamble tolerance set, only a found preamble locks
        @(posedge i_core_clk);
        i_rx_active <= 1'b0;
        i_preamble_tol <= 2'h1;
        repeat (2) @(posedge i_core_clk);
        i_rx_active <= 1'b1;
        pulse(3);
        `CHK(o_gain_hold, 1'b0)
        pulse(2);
        `CHK(o_gain_hold, 1'b1)
        i_preamble_tol <= 2'h0;
      end
      @(posedge i_core_clk);
      i_rx_active <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      axi_rd(RMC_IDX_STATUS, {RMC_RESP_OKAY, 24'h0, lut, lut, 1'b0, rb[3] == 8'h00, 2'h1});
    end
    axi_wr(10'h100, 8'h5A, 4'h1, RMC_RESP_SLVERR);
    axi_rd(10'h100, {RMC_RESP_SLVERR, 32'h0});
    axi_wr(RMC_IDX_SETUP_D, 8'hA5, 4'h0, RMC_RESP_OKAY);
    axi_rd(RMC_IDX_SETUP_D, {RMC_RESP_OKAY, 24'h0, rb[2]});
    repeat (2) @(posedge i_core_clk);
    summarize();
  end
endmodule
`default_nettype wire
